/* hdl/ipr_reset_pkg.sv */
// Purpose: Shared constants and types for the processor register bank.
// Assumes: APB slave with 32-bit data and word-aligned registers.
// Notes: Fields that have no settled value at reset still reset to zero.
package ipr_reset_pkg;

    localparam int PADDR_W = 8;

    localparam logic [PADDR_W-1:0] MUC_OFF = 8'h00;
    localparam logic [PADDR_W-1:0] BIC_OFF = 8'h04;
    localparam logic [PADDR_W-1:0] CCC_OFF = 8'h08;
    localparam logic [PADDR_W-1:0] CYC_OFF = 8'h0C;
    localparam logic [PADDR_W-1:0] SLT_OFF = 8'h10;
    localparam logic [PADDR_W-1:0] DXB_OFF = 8'h14;
    localparam logic [PADDR_W-1:0] IUC_OFF = 8'h18;
    localparam logic [PADDR_W-1:0] INV_OFF = 8'h1C;
    localparam logic [PADDR_W-1:0] EXS_OFF = 8'h20;

    localparam int         MUC_W     = 12;
    localparam logic [11:0] MUC_RESET = 12'h100;

    typedef struct packed {
        logic       bad_data_parity;
        logic       bad_tag_ctrl_parity;
        logic       ext_cache_pa_disable;
        logic [2:0] cache_size;
        logic [3:0] we_ctl;
        logic [3:0] wr_speed;
        logic [3:0] rd_speed;
        logic       parity_mode;
        logic       ce_on_write;
        logic       forced_hit;
        logic       cache_en;
    } bic_s;

    localparam int         BIC_W     = 22;
    localparam logic [21:0] BIC_RESET = 22'h000004;

    localparam int INV_DTB_BIT = 0;
    localparam int INV_ITB_BIT = 1;
    localparam int INV_DXB_BIT = 2;
    localparam int EXS_DONE_BIT = 31;

    localparam int         EXC_W         = 8;
    localparam int         EXS_CNT_W     = 6;
    localparam logic [5:0] EXS_LAST_READ = 6'h3F;

endpackage

/* hdl/ipr_reset_bank.sv */
// Purpose: Register bank that gives processor control registers their
//          reset state and exposes them over APB.
// Assumes: One clock pclk at 40 MHz, asynchronous active-low presetn.
// Notes: Every access takes one wait state; unmapped addresses error.
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps

// How it works
// - Memory-unit control loads 0x0100 in its low twelve bits at reset.
// - Cycle counter is disabled at reset and only counts once enabled.
// - Bus-interface control resets cache off, forced-hit off, chip enable on.
// - Bus-interface reset clears address-disable and bad tag parity fields.
// - Serial transmit register drives its pin; reset clears it to zero.
module ipr_reset_bank #(
    parameter int CYC_W = 32
) (
    input  wire logic                               pclk,
    input  wire logic                               presetn,
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [ipr_reset_pkg::PADDR_W-1:0]  paddr,
    input  wire logic [31:0]                        pwdata,
    input  wire logic [ipr_reset_pkg::EXC_W-1:0]    exc_event,
    output logic [31:0]                             prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    output logic [ipr_reset_pkg::MUC_W-1:0]         memory_unit_control,
    output ipr_reset_pkg::bic_s                     bus_interface_control,
    output logic                                    serial_line_transmit,
    output logic                                    large_page_select,
    output logic                                    return_stack_enable,
    output logic                                    dtb_invalidate,
    output logic                                    itb_invalidate
);

    logic [ipr_reset_pkg::MUC_W-1:0]     muc_q, muc_d;
    ipr_reset_pkg::bic_s                 bic_q, bic_d;
    logic                                ccc_q, ccc_d;
    logic [CYC_W-1:0]                    cyc_q, cyc_d;
    logic                                slt_q, slt_d;
    logic                                dxb_q, dxb_d;
    logic                                dxb_set_q, dxb_set_d;
    logic                                rse_q, rse_d;
    logic                                dinv_q, dinv_d;
    logic                                iinv_q, iinv_d;
    logic                                dneed_q, dneed_d;
    logic                                ineed_q, ineed_d;
    logic [ipr_reset_pkg::EXC_W-1:0]     exs_q, exs_d;
    logic [ipr_reset_pkg::EXS_CNT_W-1:0] cnt_q, cnt_d;
    logic                                done_q, done_d;
    logic [31:0]                         prdata_q, prdata_d;
    logic                                pready_q, pready_d;
    logic                                pslverr_q, pslverr_d;
    logic                                first_q;
    logic                                access;
    logic                                commit;
    logic                                hit;
    logic [31:0]                         rdata;

    assign access = psel & penable;
    assign commit = access & pready_q;

    always_comb begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        unique case (paddr)
            ipr_reset_pkg::MUC_OFF: rdata = {20'h00000, muc_q};
            ipr_reset_pkg::BIC_OFF: rdata = {10'h000, bic_q};
            ipr_reset_pkg::CCC_OFF: rdata = {31'h0, ccc_q};
            ipr_reset_pkg::CYC_OFF: rdata = 32'(cyc_q);
            ipr_reset_pkg::SLT_OFF: rdata = {31'h0, slt_q};
            ipr_reset_pkg::DXB_OFF: rdata = {31'h0, dxb_q};
            ipr_reset_pkg::IUC_OFF: rdata = {31'h0, rse_q};
            ipr_reset_pkg::INV_OFF: rdata = {29'h0, dxb_set_q, ineed_q,
                                             dneed_q};
            ipr_reset_pkg::EXS_OFF: rdata = {done_q, 17'h0, cnt_q, exs_q};
            default:                hit   = 1'b0;
        endcase
    end

    always_comb begin
        muc_d     = muc_q;
        bic_d     = bic_q;
        ccc_d     = ccc_q;
        cyc_d     = cyc_q;
        slt_d     = slt_q;
        dxb_d     = dxb_q;
        dxb_set_d = dxb_set_q;
        rse_d     = rse_q;
        dinv_d    = 1'b0;
        iinv_d    = 1'b0;
        dneed_d   = dneed_q;
        ineed_d   = ineed_q;
        exs_d     = exs_q;
        cnt_d     = cnt_q;
        done_d    = done_q;
        prdata_d  = prdata_q;
        pready_d  = 1'b0;
        pslverr_d = pslverr_q;
        if (ccc_q) begin
            cyc_d = cyc_q + CYC_W'(1);
        end
        if (access && !pready_q) begin
            pready_d  = 1'b1;
            pslverr_d = ~hit;
            prdata_d  = rdata;
        end
        if (commit && pwrite && hit) begin
            unique case (paddr)
                ipr_reset_pkg::MUC_OFF: muc_d = pwdata[11:0];
                ipr_reset_pkg::BIC_OFF: bic_d = pwdata[21:0];
                ipr_reset_pkg::CCC_OFF: ccc_d = pwdata[0];
                ipr_reset_pkg::CYC_OFF: cyc_d = pwdata[CYC_W-1:0];
                ipr_reset_pkg::SLT_OFF: slt_d = pwdata[0];
                ipr_reset_pkg::DXB_OFF: begin
                    dxb_d     = pwdata[0];
                    dxb_set_d = 1'b1;
                end
                ipr_reset_pkg::IUC_OFF: rse_d = pwdata[0];
                ipr_reset_pkg::INV_OFF: begin
                    dinv_d = pwdata[ipr_reset_pkg::INV_DTB_BIT];
                    iinv_d = pwdata[ipr_reset_pkg::INV_ITB_BIT];
                    if (pwdata[ipr_reset_pkg::INV_DTB_BIT]) begin
                        dneed_d = 1'b0;
                    end
                    if (pwdata[ipr_reset_pkg::INV_ITB_BIT]) begin
                        ineed_d = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // Read-to-clear runs before new events are merged, so that an event
        // in the clearing cycle survives.
        if (commit && !pwrite && paddr == ipr_reset_pkg::EXS_OFF) begin
            cnt_d = cnt_q + 6'h01;
            if (cnt_q == ipr_reset_pkg::EXS_LAST_READ) begin
                exs_d  = '0;
                done_d = 1'b1;
            end
        end
        exs_d = exs_d | exc_event;
    end

    // The reset values for undefined fields are zero so that simulation
    // never carries unknowns into software that forgets to initialise.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            muc_q     <= ipr_reset_pkg::MUC_RESET;
            bic_q     <= ipr_reset_pkg::BIC_RESET;
            ccc_q     <= 1'b0;
            cyc_q     <= '0;
            slt_q     <= 1'b0;
            dxb_q     <= 1'b0;
            dxb_set_q <= 1'b0;
            rse_q     <= 1'b0;
            dinv_q    <= 1'b0;
            iinv_q    <= 1'b0;
            dneed_q   <= 1'b1;
            ineed_q   <= 1'b1;
            exs_q     <= '0;
            cnt_q     <= '0;
            done_q    <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            muc_q     <= muc_d;
            bic_q     <= bic_d;
            ccc_q     <= ccc_d;
            cyc_q     <= cyc_d;
            slt_q     <= slt_d;
            dxb_q     <= dxb_d;
            dxb_set_q <= dxb_set_d;
            rse_q     <= rse_d;
            dinv_q    <= dinv_d;
            iinv_q    <= iinv_d;
            dneed_q   <= dneed_d;
            ineed_q   <= ineed_d;
            exs_q     <= exs_d;
            cnt_q     <= cnt_d;
            done_q    <= done_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    assign prdata                = prdata_q;
    assign pready                = pready_q;
    assign pslverr               = pslverr_q;
    assign memory_unit_control   = muc_q;
    assign bus_interface_control = bic_q;
    assign serial_line_transmit  = slt_q;
    assign large_page_select     = dxb_q;
    assign return_stack_enable   = rse_q;
    assign dtb_invalidate        = dinv_q;
    assign itb_invalidate        = iinv_q;

    a_muc_reset_val: assert property (
        @(posedge pclk) disable iff (!presetn)
        first_q |-> memory_unit_control == ipr_reset_pkg::MUC_RESET)
        else $error("memory unit control wrong after reset");

    a_cyc_reset_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        first_q |-> !ccc_q ##1 $stable(cyc_q))
        else $error("cycle counter enabled or moving after reset");

    a_cyc_hold_off: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!ccc_q && !(commit && pwrite && paddr == ipr_reset_pkg::CYC_OFF))
        |=> cyc_q == $past(cyc_q))
        else $error("cycle counter advanced while disabled");

    a_bic_reset_ctl: assert property (
        @(posedge pclk) disable iff (!presetn)
        first_q |-> (!bus_interface_control.cache_en &&
                     !bus_interface_control.forced_hit &&
                     bus_interface_control.ce_on_write))
        else $error("bus interface control wrong after reset");

    a_bic_reset_err: assert property (
        @(posedge pclk) disable iff (!presetn)
        first_q |-> (!bus_interface_control.ext_cache_pa_disable &&
                     !bus_interface_control.bad_tag_ctrl_parity))
        else $error("bus interface error fields not cleared at reset");

    a_serial_pin_wr: assert property (
        @(posedge pclk) disable iff (!presetn)
        (commit && pwrite && paddr == ipr_reset_pkg::SLT_OFF)
        |=> serial_line_transmit == $past(pwdata[0]))
        else $error("serial pin did not follow its register write");

endmodule

/* tb/fw_apb_master.sv */
// Purpose: Firmware-side model that issues APB transfers to the bank.
// Assumes: One transfer at a time, called from procedural code.
// Notes: Released write data is inverted so stale data never looks valid.
`timescale 1ns/1ps
module fw_apb_master (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    logic hung;
    initial begin
        hung = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // The bound on the wait keeps a silent slave from hanging the run.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        hung = (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask
endmodule

/* tb/tb_ipr_reset_bank.sv */
// Purpose: Self-checking bench for the register bank reset state.
// Assumes: APB access through the firmware model, 40 MHz clock.
// Notes: Firmware duties are issued here as call sequences.
`timescale 1ns/1ps
module tb_ipr_reset_bank;
    logic                pclk, presetn, psel, penable, pwrite;
    logic                pready, pslverr, err, slt, lps, rse, dinv, iinv;
    logic [7:0]          paddr, exc_event;
    logic [31:0]         pwdata, prdata, rd, rd2;
    logic [11:0]         muc;
    ipr_reset_pkg::bic_s bic, bic_w;
    int                  fails, n_checks;

    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;

    ipr_reset_bank i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .exc_event(exc_event), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .memory_unit_control(muc),
        .bus_interface_control(bic), .serial_line_transmit(slt),
        .large_page_select(lps), .return_stack_enable(rse),
        .dtb_invalidate(dinv), .itb_invalidate(iinv));

    fw_apb_master i_fw (.pclk(pclk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        i_fw.xfer(w, a, d, rd, err);
        if (i_fw.hung) begin
            fails++;
            wrap_up();
        end
    endtask

    task automatic chk_reset();
        chk({20'h0, muc}, {20'h0, ipr_reset_pkg::MUC_RESET});
        chk({31'h0, bic.cache_en}, 32'h0);
        chk({31'h0, bic.forced_hit}, 32'h0);
        chk({31'h0, bic.ce_on_write}, 32'h1);
        chk({31'h0, bic.ext_cache_pa_disable}, 32'h0);
        chk({31'h0, bic.bad_tag_ctrl_parity}, 32'h0);
    endtask

    initial begin
        presetn = 1'b0;
        exc_event = 8'h00;
        fails = 0;
        n_checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        #1 chk_reset();
        acc(0, ipr_reset_pkg::MUC_OFF, 32'h0);
        chk(rd, 32'h100);
        acc(0, ipr_reset_pkg::INV_OFF, 32'h0);
        chk(rd & 32'h3, 32'h3);
        acc(0, ipr_reset_pkg::CYC_OFF, 32'h0);
        rd2 = rd;
        acc(0, ipr_reset_pkg::CYC_OFF, 32'h0);
        chk(rd, rd2);
        // Reads are four cycles apart, so a running counter moves by four.
        acc(1, ipr_reset_pkg::CCC_OFF, 32'h1);
        acc(0, ipr_reset_pkg::CYC_OFF, 32'h0);
        rd2 = rd;
        acc(0, ipr_reset_pkg::CYC_OFF, 32'h0);
        chk(rd - rd2, 32'h4);
        // A loaded value is sampled two counts later by the next read.
        acc(1, ipr_reset_pkg::CYC_OFF, 32'h100);
        acc(0, ipr_reset_pkg::CYC_OFF, 32'h0);
        chk(rd, 32'h102);
        bic_w = '0;
        bic_w.rd_speed = 4'h3;
        bic_w.wr_speed = 4'h5;
        bic_w.we_ctl = 4'hA;
        bic_w.cache_size = 3'h2;
        bic_w.ce_on_write = 1'b1;
        acc(1, ipr_reset_pkg::BIC_OFF, {10'h0, bic_w});
        bic_w.cache_en = 1'b1;
        acc(1, ipr_reset_pkg::BIC_OFF, {10'h0, bic_w});
        #1 chk({10'h0, bic}, {10'h0, bic_w});
        acc(1, ipr_reset_pkg::DXB_OFF, 32'h1);
        #1 chk({31'h0, lps}, 32'h1);
        acc(1, ipr_reset_pkg::INV_OFF, 32'h3);
        #1 chk({30'h0, iinv, dinv}, 32'h3);
        @(posedge pclk);
        #1 chk({30'h0, iinv, dinv}, 32'h0);
        acc(0, ipr_reset_pkg::INV_OFF, 32'h0);
        chk(rd & 32'h7, 32'h4);
        acc(1, ipr_reset_pkg::SLT_OFF, 32'h1);
        #1 chk({31'h0, slt}, 32'h1);
        acc(1, ipr_reset_pkg::SLT_OFF, 32'h0);
        #1 chk({31'h0, slt}, 32'h0);
        acc(1, ipr_reset_pkg::IUC_OFF, 32'h1);
        #1 chk({31'h0, rse}, 32'h1);
        @(posedge pclk);
        exc_event <= 8'h5A;
        @(posedge pclk);
        exc_event <= 8'h00;
        for (int i = 0; i < 63; i++)
            acc(0, ipr_reset_pkg::EXS_OFF, 32'h0);
        chk(rd & 32'h800000FF, 32'h5A);
        acc(0, ipr_reset_pkg::EXS_OFF, 32'h0);
        acc(0, ipr_reset_pkg::EXS_OFF, 32'h0);
        chk(rd & 32'h800000FF, 32'h80000000);
        acc(0, 8'h24, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        acc(1, 8'h02, 32'hFFF);
        #1 chk({err, 19'h0, muc}, 32'h80000100);
        acc(1, ipr_reset_pkg::MUC_OFF, 32'hABC);
        #1 chk({20'h0, muc}, 32'hABC);
        // A second reset mid-run must restore the memory-unit and bus-interface reset fields.
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        #1 chk_reset();
        @(posedge pclk);
        presetn <= 1'b1;
        acc(0, ipr_reset_pkg::INV_OFF, 32'h0);
        chk(rd & 32'h3, 32'h3);
        // The counter ran before this reset, so it must now stand still.
        acc(0, ipr_reset_pkg::CCC_OFF, 32'h0);
        chk(rd, 32'h0);
        acc(0, ipr_reset_pkg::CYC_OFF, 32'h0);
        rd2 = rd;
        acc(0, ipr_reset_pkg::CYC_OFF, 32'h0);
        chk(rd, rd2);
        wrap_up();
    end
endmodule
